// >>> verilog/pwmpo_top.sv
// six-channel pulse-width generator core with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "pwmpo_consts.svh"

// Summary of operation
// - override on: even pin follows its level bit, 0 inactive, 1 active
// - override odd pin: 0 inactive, 1 complement of even or active
// - read-only register shows 15-bit period counter
// - counter register bit 15 reads zero, writes ignored
// - 15-bit modulo register sets period in clock periods
// - modulo register bit 15 reads zero, writes ignored
// - written modulo buffered until load-ok and next load cycle
// - modulo read returns buffered value
// - six signed 16-bit width registers set pulse widths
// - written width buffered until load-ok and next load cycle
// - width read returns buffered value
// - width zero or negative keeps output off whole period
// - width at or above modulo keeps output on whole period
// - active means high, inactive means low
// - six override enables, reset clears them
module pwmpo_top
   import pwmpo_pkg::*;
#(
   parameter int NCH = 6,
   parameter int CW  = 15
) (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic [NCH-1:0]   pwm_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                  wr_pend;
      logic [11:0]           wr_addr;
      logic [31:0]           rdata;
      logic [CW-1:0]         cnt;
      logic [CW-1:0]         cmod_buf;
      logic [CW-1:0]         cmod_act;
      logic [NCH-1:0][15:0]  val_buf;
      logic [NCH-1:0][15:0]  val_act;
      logic                  load_ok;
      logic                  indep;
      logic [NCH-1:0]        sw_override_enable;
      logic [NCH-1:0]        sw_output_level;
      logic [NCH-1:0]        pins;
      logic                  ready;
      logic                  resp;
   } pwmpo_state_t;

   pwmpo_state_t s_q;
   pwmpo_state_t s_d;
   logic [NCH-1:0] gen_active;
   logic           boundary;
   logic           rd_take;
   logic [11:0]    rd_addr;

   // ----------------------------------------------------------------
   // channel comparators
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         pwmpo_chan #(.CW(CW)) u_chan (
            .count  (s_q.cnt),
            .modulo (s_q.cmod_act),
            .width  (s_q.val_act[g]),
            .active (gen_active[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   assign boundary = ({1'b0, s_q.cnt} + 16'h0001 >= {1'b0, s_q.cmod_act});
   assign rd_take  = hsel && hready && htrans == `PWMPO_HTRANS_NONSEQ && !hwrite;
   assign rd_addr  = haddr[11:0];

   always_comb begin
      s_d = s_q;
      // period counter wraps at the active modulo; modulo 0 holds at 0
      if (boundary) begin
         s_d.cnt = '0;
      end else begin
         s_d.cnt = s_q.cnt + 15'h0001;
      end
      // write data phase; a late load-ok write still wins over the clear
      if (boundary && s_q.load_ok) begin
         s_d.cmod_act = s_q.cmod_buf;
         s_d.val_act  = s_q.val_buf;
         s_d.load_ok  = 1'b0;
      end
      s_d.wr_pend = 1'b0;
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            `PWMPO_OFF_CMOD: s_d.cmod_buf = hwdata[CW-1:0];
            `PWMPO_OFF_CTRL: begin
               if (hwdata[`PWMPO_CTRL_LOAD_OK_BIT]) begin
                  s_d.load_ok = 1'b1;
               end
               s_d.indep = hwdata[`PWMPO_CTRL_INDEP_BIT];
            end
            `PWMPO_OFF_OUT: begin
               s_d.sw_output_level    = hwdata[NCH-1:0];
               s_d.sw_override_enable = hwdata[`PWMPO_OUT_EN_LSB +: NCH];
            end
            default: begin
               if (s_q.wr_addr >= `PWMPO_OFF_VAL0 && s_q.wr_addr <= `PWMPO_OFF_LAST) begin
                  s_d.val_buf[3'((s_q.wr_addr - `PWMPO_OFF_VAL0) >> 2)] = hwdata[15:0];
               end
            end
         endcase
      end
      if (hsel && hready && htrans == `PWMPO_HTRANS_NONSEQ && hwrite) begin
         s_d.wr_pend = 1'b1;
         s_d.wr_addr = haddr[11:0];
      end
      // read data registered in the address phase
      if (rd_take) begin
         case (rd_addr)
            `PWMPO_OFF_CNTR: s_d.rdata = {17'h00000, s_q.cnt};
            `PWMPO_OFF_CMOD: s_d.rdata = {17'h00000, s_q.cmod_buf};
            `PWMPO_OFF_CTRL: s_d.rdata = {30'h00000000, s_q.indep, s_q.load_ok};
            `PWMPO_OFF_OUT:  s_d.rdata = {18'h00000, s_q.sw_override_enable, 2'h0, s_q.sw_output_level};
            default: begin
               if (rd_addr >= `PWMPO_OFF_VAL0 && rd_addr <= `PWMPO_OFF_LAST) begin
                  s_d.rdata = {16'h0000, s_q.val_buf[3'((rd_addr - `PWMPO_OFF_VAL0) >> 2)]};
               end else begin
                  s_d.rdata = 32'h00000000;
               end
            end
         endcase
      end
      // pin drive; level bit of odd pins is software's to set in pairs
      for (int i = 0; i < NCH; i++) begin
         if (!s_q.sw_override_enable[i]) begin
            s_d.pins[i] = gen_active[i];
         end else if (i % 2 == 0) begin
            s_d.pins[i] = s_q.sw_output_level[i];
         end else if (!s_q.sw_output_level[i]) begin
            s_d.pins[i] = 1'b0;
         end else if (s_q.indep) begin
            s_d.pins[i] = 1'b1;
         end else begin
            s_d.pins[i] = ~s_d.pins[i-1];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_q.wr_pend            <= 1'b0;
         s_q.wr_addr            <= 12'h000;
         s_q.rdata              <= 32'h00000000;
         s_q.cnt                <= 15'h0000;
         s_q.cmod_buf           <= `PWMPO_CMOD_RST;
         s_q.cmod_act           <= `PWMPO_CMOD_RST;
         s_q.val_buf            <= '0;
         s_q.val_act            <= '0;
         s_q.load_ok            <= 1'b0;
         s_q.indep              <= 1'b0;
         s_q.sw_override_enable <= '0;
         s_q.sw_output_level    <= '0;
         s_q.pins               <= '0;
         s_q.ready              <= 1'b1;
         s_q.resp               <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // zero-wait slave, always okay; kept in flops so every output leaves a register
   assign hreadyout = s_q.ready;
   assign hresp     = s_q.resp;
   assign hrdata    = s_q.rdata;
   assign pwm_out   = s_q.pins;

   // ----------------------------------------------------------------
   // assertions: override pairs
   // ----------------------------------------------------------------
   generate
      for (g = 0; g < NCH / 2; g++) begin : g_pair_chk
         a_ovr_even_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
            $past(s_q.sw_override_enable[2*g])
            |-> pwm_out[2*g] == $past(s_q.sw_output_level[2*g]))
            else $error("even override pin wrong");

         a_ovr_odd_low: assert property (@(posedge ref_clk) disable iff (!resetn)
            $past(s_q.sw_override_enable[2*g+1] && !s_q.sw_output_level[2*g+1])
            |-> !pwm_out[2*g+1])
            else $error("odd override pin not low");

         a_ovr_odd_cmp: assert property (@(posedge ref_clk) disable iff (!resetn)
            $past(s_q.sw_override_enable[2*g+1] && s_q.sw_output_level[2*g+1] && !s_q.indep)
            |-> pwm_out[2*g+1] == !pwm_out[2*g])
            else $error("odd pin not complement");

         a_ovr_odd_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
            $past(s_q.sw_override_enable[2*g+1] && s_q.sw_output_level[2*g+1] && s_q.indep)
            |-> pwm_out[2*g+1])
            else $error("independent odd pin not high");
      end
   endgenerate

   // ----------------------------------------------------------------
   // assertions: generator channels
   // ----------------------------------------------------------------
   generate
      for (g = 0; g < NCH; g++) begin : g_chan_chk
         a_pin_normal: assert property (@(posedge ref_clk) disable iff (!resetn)
            !$past(s_q.sw_override_enable[g])
            |-> pwm_out[g] == $past(gen_active[g]))
            else $error("pin does not follow generator");

         a_width_neg: assert property (@(posedge ref_clk) disable iff (!resetn)
            !s_q.sw_override_enable[g] && (s_q.val_act[g][15] || s_q.val_act[g] == 16'h0000)
            |=> !pwm_out[g])
            else $error("non-positive width drove output");

         a_width_full: assert property (@(posedge ref_clk) disable iff (!resetn)
            !s_q.sw_override_enable[g] && !s_q.val_act[g][15] && s_q.val_act[g] != 16'h0000
            && {1'b0, s_q.val_act[g][14:0]} >= {1'b0, s_q.cmod_act}
            |=> pwm_out[g])
            else $error("full width not on");
      end
   endgenerate

   // ----------------------------------------------------------------
   // assertions: counter, buffers, loads, register reads and reset
   // ----------------------------------------------------------------
   a_cnt_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.cmod_act != 15'h0000
      |-> s_q.cnt < s_q.cmod_act)
      else $error("counter beyond modulo");

   a_cnt_step: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.cmod_act != 15'h0000 && !boundary
      |=> s_q.cnt == $past(s_q.cnt) + 15'h0001)
      else $error("counter did not step");

   a_cnt_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      boundary
      |=> s_q.cnt == 15'h0000)
      else $error("counter did not wrap");

   a_cntr_rd_top: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr == `PWMPO_OFF_CNTR
      |=> hrdata[15] == 1'b0)
      else $error("counter bit 15 not zero");

   a_cntr_rd_val: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr == `PWMPO_OFF_CNTR
      |=> hrdata[CW-1:0] == $past(s_q.cnt))
      else $error("counter read wrong");

   a_cmod_rd_buf: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr == `PWMPO_OFF_CMOD
      |=> hrdata == {17'h00000, $past(s_q.cmod_buf)})
      else $error("modulo read not buffer");

   a_cmod_wr_buf: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.wr_pend && s_q.wr_addr == `PWMPO_OFF_CMOD
      |=> s_q.cmod_buf == $past(hwdata[CW-1:0]))
      else $error("modulo write not buffered");

   a_load_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(boundary && s_q.load_ok)
      |=> s_q.cmod_act == $past(s_q.cmod_act) && s_q.val_act == $past(s_q.val_act))
      else $error("active copy changed without load");

   a_load_take: assert property (@(posedge ref_clk) disable iff (!resetn)
      boundary && s_q.load_ok && !s_q.wr_pend
      |=> s_q.cmod_act == $past(s_q.cmod_buf) && !s_q.load_ok)
      else $error("load cycle missed");

   a_load_ok_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.load_ok && !boundary
      |=> s_q.load_ok)
      else $error("load-ok dropped early");

   a_ctrl_rd: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr == `PWMPO_OFF_CTRL
      |=> hrdata[`PWMPO_CTRL_LOAD_OK_BIT] == $past(s_q.load_ok))
      else $error("load-ok read wrong");

   a_val_rd_buf: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr == `PWMPO_OFF_VAL0
      |=> hrdata[15:0] == $past(s_q.val_buf[0]))
      else $error("width read not buffer");

   a_val_wr_buf: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.wr_pend && s_q.wr_addr == `PWMPO_OFF_VAL0
      |=> s_q.val_buf[0] == $past(hwdata[15:0]))
      else $error("width write not buffered");

   a_ovr_rd_en: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr == `PWMPO_OFF_OUT
      |=> hrdata[`PWMPO_OUT_EN_LSB +: NCH] == $past(s_q.sw_override_enable))
      else $error("override enable read wrong");

   a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_take && rd_addr > `PWMPO_OFF_LAST
      |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");

   a_reset_ovr: assert property (@(posedge ref_clk)
      $rose(resetn)
      |-> s_q.sw_override_enable == '0)
      else $error("override enables not cleared");

   // ----------------------------------------------------------------
   // covers
   // ----------------------------------------------------------------
   c_load_cycle: cover property (@(posedge ref_clk) disable iff (!resetn) boundary && s_q.load_ok);
   c_odd_cmp:    cover property (@(posedge ref_clk) disable iff (!resetn)
      s_q.sw_override_enable[1] && s_q.sw_output_level[1] && !s_q.indep);
   c_pwm_edge:   cover property (@(posedge ref_clk) disable iff (!resetn) $rose(pwm_out[2]));
   c_width_neg:  cover property (@(posedge ref_clk) disable iff (!resetn)
      !s_q.sw_override_enable[2] && s_q.val_act[2][15]);
   c_odd_ind:    cover property (@(posedge ref_clk) disable iff (!resetn)
      s_q.sw_override_enable[1] && s_q.sw_output_level[1] && s_q.indep);
endmodule
`default_nettype wire

// >>> verilog/pwmpo_consts.svh
// offsets, field positions, reset values and bus codes of the pulse-width generator
`ifndef PWMPO_CONSTS_SVH
`define PWMPO_CONSTS_SVH
`define PWMPO_OFF_CNTR      12'h000
`define PWMPO_OFF_CMOD      12'h004
`define PWMPO_OFF_CTRL      12'h008
`define PWMPO_OFF_OUT       12'h00c
`define PWMPO_OFF_VAL0      12'h010
`define PWMPO_OFF_LAST      12'h024
`define PWMPO_CTRL_LOAD_OK_BIT 0
`define PWMPO_CTRL_INDEP_BIT 1
`define PWMPO_OUT_EN_LSB    8
`define PWMPO_CMOD_RST      15'h0000
`define PWMPO_VAL_RST       16'h0000
`define PWMPO_HTRANS_NONSEQ 2'h2
`endif

// >>> verilog/pwmpo_pkg.sv
// types shared by the pulse-width generator files
package pwmpo_pkg;
   typedef struct packed {
      logic        sel;
      logic [1:0]  trans;
      logic [31:0] addr;
      logic        write;
      logic [2:0]  size;
      logic        ready;
      logic [31:0] wdata;
   } pwmpo_ahb_req_t;

   typedef struct packed {
      logic        readyout;
      logic        resp;
      logic [31:0] rdata;
   } pwmpo_ahb_rsp_t;

   typedef enum logic [1:0] {
      PWMPO_WIDTH_OFF  = 2'b00,
      PWMPO_WIDTH_ON   = 2'b01,
      PWMPO_WIDTH_CMP  = 2'b10
   } pwmpo_width_mode_t;
endpackage

// >>> verilog/pwmpo_chan.sv
// one channel comparator: width against counter with saturation
`timescale 1ns/100ps
`default_nettype none
module pwmpo_chan
   import pwmpo_pkg::*;
#(
   parameter int CW = 15
) (
   input  wire logic [CW-1:0] count,
   input  wire logic [CW-1:0] modulo,
   input  wire logic [15:0]   width,
   output logic               active
);
   pwmpo_width_mode_t mode;
   always_comb begin
      // sign bit set or zero: never active
      if (width[15] || width == 16'h0000) begin
         mode = PWMPO_WIDTH_OFF;
      end else if ({1'b0, width[14:0]} >= {1'b0, modulo}) begin
         mode = PWMPO_WIDTH_ON;
      end else begin
         mode = PWMPO_WIDTH_CMP;
      end
      case (mode)
         PWMPO_WIDTH_OFF: active = 1'b0;
         PWMPO_WIDTH_ON:  active = 1'b1;
         PWMPO_WIDTH_CMP: active = ({1'b0, count} < {1'b0, width[14:0]});
         default:         active = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// >>> verification/pwmpo_stage.sv
// power stage model: counts the on cycles of each driven switch
`timescale 1ns/100ps
`default_nettype none
module pwmpo_stage (
   input  wire logic            ref_clk,
   input  wire logic            resetn,
   input  wire logic            clr,
   input  wire logic [5:0]      pins,
   output logic      [5:0][7:0] on_cnt
);
   // a high pin closes its switch; counting over whole periods makes phase irrelevant
   always_ff @(posedge ref_clk or negedge resetn) begin
      for (int i = 0; i < 6; i++) begin
         if (!resetn || clr) begin
            on_cnt[i] <= 8'h00;
         end else begin
            on_cnt[i] <= on_cnt[i] + {7'h00, pins[i]};
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench of the six-channel pulse-width generator core
`timescale 1ns/100ps
`default_nettype none
`include "pwmpo_consts.svh"
module tb
   import pwmpo_pkg::*;
;
   logic            ref_clk = 1'b0;
   logic            resetn = 1'b0;
   logic            hsel = 1'b0;
   logic            hwrite = 1'b0;
   logic            clr = 1'b0;
   logic [1:0]      htrans = 2'h0;
   logic [2:0]      hsize = 3'h2;
   logic [31:0]     haddr = 32'h0;
   logic [31:0]     hwdata = 32'h0;
   logic            hreadyout;
   logic            hresp;
   logic [31:0]     hrdata;
   logic [5:0]      pwm_out;
   logic [5:0][7:0] on_cnt;
   wire  logic      hready = hreadyout;
   int              err_count = 0;
   int              checked = 0;

   always #20 ref_clk = ~ref_clk;

   pwmpo_top #(.NCH(6), .CW(15)) uut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out));
   pwmpo_stage stage (.ref_clk(ref_clk), .resetn(resetn), .clr(clr), .pins(pwm_out), .on_cnt(on_cnt));

   // ----------------------------------------
   // bus and check helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // no fixed latency assumed: both phases wait for hready, the watchdog ends a hang
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= `PWMPO_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(v, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic load();
      logic [31:0] v;
      v = 32'h1;
      wr(`PWMPO_OFF_CTRL, 32'h1);
      for (int i = 0; i < 100 && v[0]; i++) bus(1'b0, `PWMPO_OFF_CTRL, 32'h0, v);
      chk(v & 32'h1, 32'h0);
   endtask

   task automatic measure(input logic [5:0][7:0] exp);
      repeat (2) @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (40) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int i = 0; i < 6; i++) chk({24'h0, on_cnt[i]}, {24'h0, exp[i]});
      @(posedge ref_clk);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] a;
      logic [31:0] b;
      rdc(`PWMPO_OFF_CNTR, 32'h0);
      rdc(`PWMPO_OFF_VAL0, 32'h0);
      wr(12'h028, 32'hdead);
      rdc(12'h028, 32'h0);
      wr(`PWMPO_OFF_CMOD, 32'hffffffff);
      rdc(`PWMPO_OFF_CMOD, 32'h7fff);
      // zero modulo parks the counter, so a write that stuck would show here
      wr(`PWMPO_OFF_CNTR, 32'hffffffff);
      rdc(`PWMPO_OFF_CNTR, 32'h0);
      wr(`PWMPO_OFF_CMOD, 32'd10);
      load();
      bus(1'b0, `PWMPO_OFF_CNTR, 32'h0, a);
      bus(1'b0, `PWMPO_OFF_CNTR, 32'h0, b);
      chk((b + 32'd10 - a) % 32'd10, 32'd2);
      $display("register test done");
   endtask

   task automatic t_width();
      logic [15:0] w [6] = '{16'd3, 16'd0, 16'hffff, 16'd10, 16'd20, 16'd5};
      for (int i = 0; i < 6; i++) wr(`PWMPO_OFF_VAL0 + 12'(4 * i), {16'h0, w[i]});
      for (int i = 0; i < 6; i++) rdc(`PWMPO_OFF_VAL0 + 12'(4 * i), {16'h0, w[i]});
      measure('0);
      load();
      measure({8'd20, 8'd40, 8'd40, 8'd0, 8'd0, 8'd12});
      wr(`PWMPO_OFF_CMOD, 32'd20);
      measure({8'd20, 8'd40, 8'd40, 8'd0, 8'd0, 8'd12});
      rdc(`PWMPO_OFF_CMOD, 32'd20);
      load();
      measure({8'd10, 8'd40, 8'd20, 8'd0, 8'd0, 8'd6});
      $display("width test done");
   endtask

   task automatic t_override();
      logic [6:0] lv [4] = '{7'h09, 7'h00, 7'h6a, 7'h7f};
      wr(`PWMPO_OFF_OUT, 32'h1000);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, pwm_out[4]}, 32'h0);
      wr(`PWMPO_OFF_OUT, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, pwm_out[4]}, 32'h1);
      // bit 6 of each entry picks independent mode
      for (int i = 0; i < 4; i++) begin
         wr(`PWMPO_OFF_CTRL, {30'h0, lv[i][6], 1'b0});
         wr(`PWMPO_OFF_OUT, {18'h0, 6'h3f, 2'h0, lv[i][5:0]});
         repeat (2) @(posedge ref_clk);
         chk({26'h0, pwm_out}, {26'h0, lv[i][5:0]});
      end
      $display("override test done");
   endtask

   task automatic t_reset();
      resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({26'h0, pwm_out}, 32'h0);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rdc(`PWMPO_OFF_OUT, 32'h0);
      rdc(`PWMPO_OFF_CMOD, 32'h0);
      $display("reset test done");
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_width();
      t_override();
      t_reset();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
